// ==== ocp_hiccup.sv ====
`timescale 1ns/1ps
module ocp_hiccup
  import ocp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cycle_start,
  input wire logic pwm_on,
  input wire logic soft_start_done,
  input wire logic switch_node_high,
  input wire logic overcurrent_cmp,
  input wire logic threshold_too_low,
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic current_limit_sense_node_pull,
  output logic pwm_enable,
  output logic soft_start_restart,
  output logic fault,
  output logic [2:0] fault_count
);
  // pin levels after two flip-flops
  logic sw_s1_r;
  logic sw_s2_r;
  logic oc_s1_r;
  logic oc_s2_r;
  logic lo_s1_r;
  logic lo_s2_r;
  // blanking window
  logic blank_r;
  logic blank_nxt;
  logic [3:0] bcnt_r;
  logic [3:0] bcnt_nxt;
  // gate drives
  logic hs_r;
  logic hs_nxt;
  logic ls_r;
  logic ls_nxt;
  logic seen_r;
  logic seen_nxt;
  // overcurrent seen in the running cycle
  logic oc_cyc_r;
  logic oc_cyc_nxt;
  // fault counter and operating mode
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  mode_type mode_r;
  mode_type mode_nxt;
  // decoded events
  logic oc_hit;
  logic oc_seen;
  logic pulse_go;
  logic pulse_end;
  logic enter_fault;
  logic leave_fault;

  // counts down but never below zero
  function automatic logic [2:0] count_down(input logic [2:0] value);
    if (value == FAULT_ZERO)
      return FAULT_ZERO;
    return value - 3'h1;
  endfunction : count_down

  // true on the last cycle of the blanking timeout
  function automatic logic blank_expired(input logic [3:0] count);
    return count >= BLANK_CNT_MAX - 4'h1;
  endfunction : blank_expired

  // second-tier protection active
  function automatic logic is_hiccup(input mode_type mode);
    return mode == ST_HICCUP;
  endfunction : is_hiccup

  // switch node synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sw_s1_r <= 1'b0;
      sw_s2_r <= 1'b0;
    end
    else
    begin
      sw_s1_r <= switch_node_high;
      sw_s2_r <= sw_s1_r;
    end
  end

  // overcurrent comparator synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      oc_s1_r <= 1'b0;
      oc_s2_r <= 1'b0;
    end
    else
    begin
      oc_s1_r <= overcurrent_cmp;
      oc_s2_r <= oc_s1_r;
    end
  end

  // low threshold synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lo_s1_r <= 1'b0;
      lo_s2_r <= 1'b0;
    end
    else
    begin
      lo_s1_r <= threshold_too_low;
      lo_s2_r <= lo_s1_r;
    end
  end

  // sense only outside blanking while the high side conducts
  assign oc_hit = hs_r && !blank_r && oc_s2_r && !lo_s2_r;
  // a hit on the closing edge still belongs to the old cycle
  assign oc_seen = oc_cyc_r || oc_hit;
  // pulse start and end
  assign pulse_go = cycle_start && pwm_on && !is_hiccup(mode_r);
  assign pulse_end = !cycle_start && hs_r && (!pwm_on || oc_hit);

  // fault counter
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (is_hiccup(mode_r))
    begin
      if (soft_start_done)
        cnt_nxt = count_down(cnt_r);
    end
    else if (cycle_start)
    begin
      if (oc_seen)
        cnt_nxt = cnt_r + 3'h1;
      else
        cnt_nxt = count_down(cnt_r);
    end
    enter_fault = !is_hiccup(mode_r) && (cnt_nxt == FAULT_LIMIT);
    // the ramp that empties the counter ends hiccup
    leave_fault = is_hiccup(mode_r) && soft_start_done && (cnt_r <= 3'h1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_r <= FAULT_ZERO;
    else
      cnt_r <= cnt_nxt;
  end

  // overcurrent flag of the running cycle
  always_comb
  begin
    oc_cyc_nxt = oc_cyc_r;
    if (cycle_start || is_hiccup(mode_r) || enter_fault)
      oc_cyc_nxt = 1'b0;
    else if (oc_hit)
      oc_cyc_nxt = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      oc_cyc_r <= 1'b0;
    else
      oc_cyc_r <= oc_cyc_nxt;
  end

  // blanking window
  always_comb
  begin
    blank_nxt = blank_r;
    bcnt_nxt = bcnt_r;
    if (blank_r)
    begin
      bcnt_nxt = bcnt_r + 4'h1;
      if (sw_s2_r)
        blank_nxt = 1'b0;
      else if (blank_expired(bcnt_r))
        blank_nxt = 1'b0;
    end
    if (cycle_start || pulse_end || is_hiccup(mode_r))
      blank_nxt = 1'b0;
    if (pulse_go)
    begin
      blank_nxt = 1'b1;
      bcnt_nxt = 4'h0;
    end
    // a fault on this edge wins over a new pulse
    if (enter_fault)
      blank_nxt = 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      blank_r <= 1'b0;
      bcnt_r <= 4'h0;
    end
    else
    begin
      blank_r <= blank_nxt;
      bcnt_r <= bcnt_nxt;
    end
  end

  // gate drives
  always_comb
  begin
    hs_nxt = hs_r;
    ls_nxt = ls_r;
    seen_nxt = seen_r;
    if (cycle_start)
    begin
      hs_nxt = 1'b0;
      if (mode_r == ST_RUN)
        ls_nxt = 1'b0;
    end
    else if (pulse_end)
    begin
      hs_nxt = 1'b0;
      // low side only after a high-side pulse since restart
      ls_nxt = seen_r;
    end
    if (pulse_go)
    begin
      hs_nxt = 1'b1;
      ls_nxt = 1'b0;
      seen_nxt = 1'b1;
    end
    if (leave_fault)
      seen_nxt = 1'b0;
    if (is_hiccup(mode_r) || enter_fault)
    begin
      hs_nxt = 1'b0;
      ls_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hs_r <= 1'b0;
      ls_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else
    begin
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
      seen_r <= seen_nxt;
    end
  end

  // operating mode
  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      ST_SOFT:
      begin
        if (soft_start_done)
          mode_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        // leaves only through a fault
        mode_nxt = ST_RUN;
      end
      ST_HICCUP:
      begin
        if (leave_fault)
          mode_nxt = ST_SOFT;
      end
      default:
        mode_nxt = ST_SOFT;
    endcase
    if (enter_fault)
      mode_nxt = ST_HICCUP;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_r <= ST_SOFT;
    else
      mode_r <= mode_nxt;
  end

  // outputs straight from the state registers
  assign high_side_gate_drive = hs_r;
  assign low_side_gate_drive = ls_r;
  assign current_limit_sense_node_pull = blank_r;
  assign pwm_enable = !is_hiccup(mode_r);
  assign soft_start_restart = (mode_r != ST_RUN);
  assign fault = is_hiccup(mode_r);
  assign fault_count = cnt_r;
endmodule : ocp_hiccup

// ==== ocp_pkg.sv ====
package ocp_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BLANK_TIMEOUT_NS = 500;
  localparam int unsigned BLANK_TIMEOUT_CYC = (BLANK_TIMEOUT_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [2:0] FAULT_LIMIT = 3'h7;
  localparam logic [2:0] FAULT_ZERO = 3'h0;
  localparam logic [3:0] BLANK_CNT_MAX = 4'(BLANK_TIMEOUT_CYC);
  typedef enum logic [1:0] {ST_SOFT, ST_RUN, ST_HICCUP} mode_type;
endpackage : ocp_pkg

// ==== ocp_hiccup_props.sv ====
`timescale 1ns/1ps
module ocp_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic high_side_gate_drive,
  input wire logic low_side_gate_drive,
  input wire logic [2:0] fault_count,
  input wire logic current_limit_sense_node_pull,
  input wire logic pwm_enable,
  input wire logic fault
);
  wire hs = high_side_gate_drive, pull = current_limit_sense_node_pull;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  blank_on_a: assert property ($rose(hs) |-> pull) else $error("no blank");
  blank_end_a: assert property ($rose(pull) |-> ##[1:6] !pull) else $error("long blank");
  blank_hs_a: assert property (pull |-> hs) else $error("stray blank");
  drive_off_a: assert property (fault |=> !hs) else $error("drive on");
  pwm_off_a: assert property (fault |-> !pwm_enable) else $error("pwm on");
  hiccup_len_a: assert property ($rose(fault) |-> fault [*7]) else $error("short");
  restart_a: assert property ($fell(fault) |-> pwm_enable) else $error("no restart");
  fault_top_a: assert property ($rose(fault) |-> fault_count == 3'h7) else $error("top");
  ls_hiccup_a: assert property (fault |-> !low_side_gate_drive) else $error("ls on");
  no_overlap_a: assert property (!(hs && low_side_gate_drive)) else $error("overlap");
  cover property ($rose(fault));
  cover property ($fell(fault));
  cover property ($fell(pull) && hs);
endmodule : ocp_chk
bind ocp_hiccup ocp_chk chk (.*);

// ==== fet_model.sv ====
`timescale 1ns/1ps
module fet_model (
  input wire logic hs,
  input wire logic ovl,
  input wire logic stuck,
  output logic sw,
  output logic oc
);
  assign sw = hs & !stuck;
  assign oc = hs & ovl;
endmodule : fet_model

// ==== ocp_hiccup_test.sv ====
`timescale 1ns/1ps
module ocp_hiccup_test;
  logic clk = 0, rst = 1, cs = 0, dn = 0, ovl = 0, pw = 1, lo = 0, stk = 0;
  logic hs, ls, pull, pe, flt, sw, oc, ssr;
  logic [2:0] fc;
  int n_mismatch = 0, comparisons = 0;
  always #50 clk = ~clk;
  ocp_hiccup uut (.clk, .rst, .cycle_start(cs), .pwm_on(pw), .soft_start_done(dn),
    .switch_node_high(sw), .overcurrent_cmp(oc), .threshold_too_low(lo), .fault(flt),
    .high_side_gate_drive(hs), .low_side_gate_drive(ls), .current_limit_sense_node_pull(pull),
    .pwm_enable(pe), .soft_start_restart(ssr), .fault_count(fc));
  fet_model fet (.hs, .ovl, .stuck(stk), .sw, .oc);
  task chk(logic [2:0] g, e);
    comparisons++;
    n_mismatch += int'(g !== e);
    if (g !== e)
      $display("BAD %0t got %h expected %h", $time, g, e);
  endtask : chk
  task t_guard;
    chk({pe, ssr, hs}, 3'b110);
    chk({ls, flt, pull}, 3'b000);
    stk = 1;
    ovl = 1;
    lo = 1;
    cs = 1;
    #100;
    cs = 0;
    #400;
    chk(pull, 1);
    #100;
    chk(pull, 0);
    #300;
    chk({hs, ls}, 2'b10);
    cs = 1;
    #100;
    cs = 0;
    chk(fc, 0);
    lo = 0;
    #800;
    chk({hs, ls}, 2'b01);
    stk = 0;
    ovl = 0;
    cs = 1;
    #100;
    cs = 0;
    chk(fc, 1);
    pw = 0;
    #200;
    chk({hs, ls}, 2'b01);
    pw = 1;
    cs = 1;
    #100;
    cs = 0;
    chk(fc, 0);
    dn = 1;
    #100;
    dn = 0;
    chk({ssr, pe}, 2'b01);
  endtask : t_guard
  task t_trip;
    ovl = 1;
    for (int k = 0; k < 8; k++)
    begin
      cs = 1;
      #100;
      cs = 0;
      chk(fc, 3'(k));
      #300;
      chk(pull, 0);
      #500;
      chk({flt, hs, ls}, {k == 7, 1'b0, k < 7});
    end
  endtask : t_trip
  task t_hiccup;
    for (int k = 6; k >= 0; k--)
    begin
      dn = 1;
      #100;
      dn = 0;
      chk(fc, 3'(k));
      #100;
    end
    chk(pe, 1);
    chk({ssr, ls, flt}, 3'b100);
  endtask : t_hiccup
  task end_sim;
    $display("n_mismatch %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial
  begin
    #1160;
    rst = 0;
    t_guard;
    t_trip;
    t_hiccup;
    t_trip;
    end_sim;
  end
  initial
  begin
    #60000;
    n_mismatch++;
    end_sim;
  end
endmodule : ocp_hiccup_test
